// >>> core/stream_write_dma_command.sv
// streaming dma write command interpreter with apb register access
//
// How it works
// - command code 3Ah written to the command register starts a streaming write
// - write data arrives by dma word handshake, never by programmed transfers
// - requested feature options are carried out before completion is posted
// - continuous-write set means transfer and media errors never abort the command
// - continuous-write errors: full transfer, then busy clear, stream error set, error clear
// - continuous-write errors are recorded by kind in the error log
// - continuous-write time limit expiry stops, clears busy, logs the expiry bit
// - with continuous-write the device tries to move the full amount within the time limit
// - urgent commands are flagged to the media side and bounded by the timer
// - status shows busy 7, ready 6, stream error 5, deferred error 4 zero, error 0
// - flush bit set means wait for media flush before completion
// - the three-bit stream id selects that stream's stored configuration
// - zero limit uses the stream default; zero default disables the limit
// - a sector count of zero transfers 65536 sectors
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module stream_write_dma_command
  import stream_dma_pkg::*;
#(
  parameter int         WPS      = WORDS_PER_SECTOR, // 16-bit words per sector
  parameter logic [15:0] UNIT_US = 16'(TIME_UNIT_US), // microseconds per limit step
  parameter logic [7:0]  MIN_LIM = 8'(MIN_LIMIT)      // shortest limit in steps
) (
  input  wire logic        pclk,          // clock, 100 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped address
  input  wire logic        dma_valid,     // host word present
  input  wire logic [15:0] dma_data,      // host word
  input  wire logic        dma_crc_err,   // interface crc error on word
  output logic             dma_req,       // device accepts words
  output logic             media_we,      // pulse: word to media
  output logic      [15:0] media_data,    // word to media
  output logic      [47:0] media_lba,     // sector address; already steps to the next sector with a sector's last word
  output logic      [2:0]  media_stream,  // selected stream
  output logic             urgent_request, // urgent command running
  input  wire logic        media_idnf,    // pulse: sector id not found
  input  wire logic        media_abort,   // pulse: media aborted write
  output logic             flush_req,     // level: flush stream to media
  input  wire logic        flush_done,    // pulse: flush finished
  output logic             irq            // level interrupt
);

  cmd_state_type state_r;
  logic [7:0]    feat_cur_r, feat_prev_r;
  logic [15:0]   count_r;
  logic [47:0]   lba_r;
  logic [7:0]    dflt_limit_r [8];
  logic [16:0]   sectors_left_r;
  logic [15:0]   word_cnt_r;
  logic          bsy_r, se_r, err_r;
  logic [7:0]    err_reg_r, err_log_r;
  logic [2:0]    int_stat_r, int_mask_r, int_set;
  logic          continuous_write_enable, flush_sel;
  logic [2:0]    sid;
  logic [7:0]    lim_sel, completion_time_limit;
  logic [23:0]   limit_us;
  logic          time_limit_expired;
  logic          wr_fire, rd_take, cmd_wr, start, bad_cmd;
  logic          word_take, last_word, err_ev, timeout, fin_ok, fin_abort, finish;
  logic [7:0]    err_kind, status_val;
  logic [31:0]   rd_val;
  logic          rd_hit;

  // ---------------------------------------------------------------
  // apb decode: answer one cycle into the access phase
  // ---------------------------------------------------------------
  assign rd_take = psel && penable && !pready;
  assign wr_fire = psel && penable && pready && pwrite;
  assign cmd_wr  = wr_fire && (paddr == OFS_COMMAND) && !bsy_r;
  assign start   = cmd_wr && (pwdata[7:0] == CMD_STREAM_WRITE);
  assign bad_cmd = cmd_wr && (pwdata[7:0] != CMD_STREAM_WRITE);

  // status as the host sees it, deferred write error held low
  assign status_val = {bsy_r, 1'b1, se_r, 1'b0, dma_req, 2'b00, err_r};

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_COMMAND:      rd_val = 32'h0000_0000;
      OFS_FEATURE:      rd_val = {16'h0000, feat_prev_r, feat_cur_r};
      OFS_COUNT:        rd_val = {16'h0000, count_r};
      OFS_LBA_LOW:      rd_val = lba_r[31:0];
      OFS_LBA_HIGH:     rd_val = {16'h0000, lba_r[47:32]};
      OFS_STATUS:       rd_val = {24'h00_0000, status_val};
      OFS_ERROR:        rd_val = {24'h00_0000, err_reg_r};
      OFS_ERROR_LOG:    rd_val = {24'h00_0000, err_log_r};
      OFS_INT_STATUS:   rd_val = {29'h0000_0000, int_stat_r};
      OFS_INT_MASK:     rd_val = {29'h0000_0000, int_mask_r};
      OFS_STREAM_DFLT:  rd_val = 32'h0000_0000;
      OFS_SECTORS_LEFT: rd_val = {15'h0000, sectors_left_r};
      default:          rd_hit = 1'b0;
    endcase
  end

  // handshake flops; data sampled when ready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_take;
      if (rd_take) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= !rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // command block registers, frozen while busy
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_cur_r  <= 8'h00;
      feat_prev_r <= 8'h00;
      count_r     <= 16'h0000;
      lba_r       <= 48'h0000_0000_0000;
    end else if (wr_fire && !bsy_r) begin
      if (paddr == OFS_FEATURE) begin
        feat_cur_r  <= pwdata[7:0];
        feat_prev_r <= pwdata[15:8];
      end
      if (paddr == OFS_COUNT) begin
        count_r <= pwdata[15:0];
      end
      if (paddr == OFS_LBA_LOW) begin
        lba_r[31:0] <= pwdata;
      end
      if (paddr == OFS_LBA_HIGH) begin
        lba_r[47:32] <= pwdata[15:0];
      end
    end
  end

  // per-stream default limits; id in bits 2:0, limit in bits 15:8
  for (genvar i = 0; i < 8; i++) begin : g_dflt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dflt_limit_r[i] <= 8'h00;
      end else if (wr_fire && (paddr == OFS_STREAM_DFLT) && (pwdata[2:0] == 3'(i))) begin
        dflt_limit_r[i] <= pwdata[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // option decode and time limit selection
  // ---------------------------------------------------------------
  assign continuous_write_enable = feat_cur_r[FEAT_WC_BIT];
  assign flush_sel = feat_cur_r[FEAT_FLUSH_BIT];
  assign sid       = feat_cur_r[FEAT_SID_MSB:0];
  assign lim_sel   = (feat_prev_r != 8'h00) ? feat_prev_r : dflt_limit_r[sid];
  assign completion_time_limit = (lim_sel < MIN_LIM) ? MIN_LIM : lim_sel;
  assign limit_us  = 24'(completion_time_limit * UNIT_US);

  // a zero selection leaves the timer disarmed
  time_limit_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (start),
    .run      (bsy_r),
    .enable   (lim_sel != 8'h00),
    .limit_us (limit_us),
    .expired  (time_limit_expired)
  );

  // ---------------------------------------------------------------
  // transfer events
  // ---------------------------------------------------------------
  assign word_take = (state_r == ST_XFER) && dma_req && dma_valid;
  assign last_word = word_take && (word_cnt_r == 16'(WPS - 1)) &&
                     (sectors_left_r == 17'h0_0001);
  assign err_kind  = {(word_take && dma_crc_err), 2'b00,
                      ((state_r == ST_XFER) && media_idnf), 1'b0,
                      ((state_r == ST_XFER) && media_abort), 2'b00};
  assign err_ev    = (err_kind != 8'h00);
  assign timeout   = time_limit_expired && (state_r != ST_IDLE);
  // errors abort only without continuous-write
  assign fin_abort = (err_ev && !continuous_write_enable) || timeout || bad_cmd;
  assign fin_ok    = ((state_r == ST_XFER) && last_word && !flush_sel) ||
                     ((state_r == ST_FLUSH) && flush_done);
  assign finish    = fin_ok || fin_abort;

  // ---------------------------------------------------------------
  // command state machine and sector walk
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r        <= ST_IDLE;
      sectors_left_r <= 17'h0_0000;
      word_cnt_r     <= 16'h0000;
      dma_req        <= 1'b0;
      flush_req      <= 1'b0;
      media_stream   <= 3'b000;
      urgent_request <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r        <= ST_XFER;
            sectors_left_r <= (count_r == 16'h0000) ? ZERO_COUNT_SECTORS
                                                    : {1'b0, count_r};
            word_cnt_r     <= 16'h0000;
            dma_req        <= 1'b1;
            media_stream   <= sid;
            urgent_request <= feat_cur_r[FEAT_URGENT_BIT];
          end
        end
        ST_XFER: begin
          if (word_take) begin
            // with continuous-write the whole count is moved even when some words are bad
            if (word_cnt_r == 16'(WPS - 1)) begin
              word_cnt_r     <= 16'h0000;
              sectors_left_r <= sectors_left_r - 17'h0_0001;
            end else begin
              word_cnt_r <= word_cnt_r + 16'h0001;
            end
          end
          if (fin_abort) begin
            state_r        <= ST_IDLE;
            dma_req        <= 1'b0;
            urgent_request <= 1'b0;
          end else if (last_word) begin
            dma_req <= 1'b0;
            if (flush_sel) begin
              state_r   <= ST_FLUSH;
              flush_req <= 1'b1;
            end else begin
              state_r        <= ST_IDLE;
              urgent_request <= 1'b0;
            end
          end
        end
        ST_FLUSH: begin
          if (flush_done || timeout) begin
            state_r        <= ST_IDLE;
            flush_req      <= 1'b0;
            urgent_request <= 1'b0;
          end
        end
        default: begin
          state_r   <= ST_IDLE;
          dma_req   <= 1'b0;
          flush_req <= 1'b0;
        end
      endcase
    end
  end

  // media write port follows each accepted word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      media_we   <= 1'b0;
      media_data <= 16'h0000;
      media_lba  <= 48'h0000_0000_0000;
    end else begin
      media_we <= word_take;
      if (start) begin
        media_lba <= lba_r;
      end else if (word_take && (word_cnt_r == 16'(WPS - 1))) begin
        media_lba <= media_lba + 48'h0000_0000_0001;
      end
      if (word_take) begin
        media_data <= dma_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // ending status, error register and error log
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsy_r     <= 1'b0;
      se_r      <= 1'b0;
      err_r     <= 1'b0;
      err_reg_r <= 8'h00;
      err_log_r <= 8'h00;
    end else if (start) begin
      bsy_r     <= 1'b1;
      se_r      <= 1'b0;
      err_r     <= 1'b0;
      err_reg_r <= 8'h00;
      err_log_r <= 8'h00;
    end else if (bad_cmd) begin
      err_r     <= 1'b1;
      err_reg_r <= 8'h00 | (8'h01 << ER_ABT);
    end else if (bsy_r) begin
      if (continuous_write_enable) begin
        // kinds of error collect in the log instead of the error bit
        err_log_r <= err_log_r | err_kind | (timeout ? 8'h01 << ER_TIME_LIMIT_EXPIRED : 8'h00);
      end
      if (finish) begin
        bsy_r <= 1'b0;
        if (continuous_write_enable) begin
          se_r  <= (err_log_r != 8'h00) || err_ev || timeout;
          err_r <= 1'b0;
        end else if (fin_abort) begin
          err_r     <= 1'b1;
          err_reg_r <= err_kind | (timeout ? 8'h01 << ER_ABT : 8'h00);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status (write one to clear), mask and output
  // ---------------------------------------------------------------
  assign int_set = {timeout && bsy_r,
                    (bsy_r && finish && (fin_abort || err_ev || err_log_r != 8'h00)) || bad_cmd,
                    (bsy_r && finish) || bad_cmd};

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 3'b000;
      int_mask_r <= 3'b000;
      irq        <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r &
                     ~((wr_fire && paddr == OFS_INT_STATUS) ? pwdata[2:0] : 3'b000)) |
                    int_set;
      if (wr_fire && paddr == OFS_INT_MASK) begin
        int_mask_r <= pwdata[2:0];
      end
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_taken;
    start && (count_r == 16'h0000);
  endsequence

  sequence wc_error_mid;
    (state_r == ST_XFER) && continuous_write_enable && err_ev && !last_word && !timeout;
  endsequence

  start_busy_a: assert property (start |=> bsy_r && state_r == ST_XFER)
    else $error("accepted stream write did not raise busy");
  zero_count_a: assert property (cmd_taken |=> sectors_left_r == ZERO_COUNT_SECTORS)
    else $error("zero count did not load 65536 sectors");
  busy_cover_a: assert property (state_r != ST_IDLE |-> bsy_r)
    else $error("busy low while command runs");
  wc_continue_a: assert property (wc_error_mid |=> state_r == ST_XFER && dma_req)
    else $error("continuous write stopped on error");
  wc_ending_a: assert property (bsy_r && finish && continuous_write_enable && err_ev
                                |=> !bsy_r && se_r && !err_r)
    else $error("continuous write ending status wrong");
  wc_expiry_a: assert property (bsy_r && timeout && continuous_write_enable
                                |=> !bsy_r && err_log_r[ER_TIME_LIMIT_EXPIRED] && state_r == ST_IDLE)
    else $error("time limit expiry not logged");
  plain_abort_a: assert property ((state_r == ST_XFER) && err_ev && !continuous_write_enable
                                  |=> err_r && !bsy_r && !dma_req)
    else $error("error without continuous write did not abort");
  flush_hold_a: assert property ((state_r == ST_FLUSH) && !flush_done && !timeout
                                 |=> bsy_r && flush_req [*1])
    else $error("completion posted before flush finished");
  stat_bits_a: assert property (bsy_r |-> status_val[ST_BSY] && status_val[ST_RDY]
                                && !status_val[ST_DWE])
    else $error("status layout wrong while busy");
  wc_log_a: assert property ((state_r == ST_XFER) && continuous_write_enable
                             && (err_kind[ER_CRC] || err_kind[ER_IDN])
                             |=> (err_log_r & 8'h90) != 8'h00)
    else $error("continuous write error kind not logged");

endmodule
`default_nettype wire

// >>> core/stream_dma_pkg.sv
// constants and types shared by the streaming dma write command block
package stream_dma_pkg;

  // ---------------------------------------------------------------
  // command codes and register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_STREAM_WRITE = 8'h3A;
  localparam logic [11:0] OFS_COMMAND      = 12'h000;
  localparam logic [11:0] OFS_FEATURE      = 12'h004;
  localparam logic [11:0] OFS_COUNT        = 12'h008;
  localparam logic [11:0] OFS_LBA_LOW      = 12'h00C;
  localparam logic [11:0] OFS_LBA_HIGH     = 12'h010;
  localparam logic [11:0] OFS_STATUS       = 12'h014;
  localparam logic [11:0] OFS_ERROR        = 12'h018;
  localparam logic [11:0] OFS_ERROR_LOG    = 12'h01C;
  localparam logic [11:0] OFS_INT_STATUS   = 12'h020;
  localparam logic [11:0] OFS_INT_MASK     = 12'h024;
  localparam logic [11:0] OFS_STREAM_DFLT  = 12'h028;
  localparam logic [11:0] OFS_SECTORS_LEFT = 12'h02C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FEAT_URGENT_BIT = 7;
  localparam int FEAT_WC_BIT     = 6;
  localparam int FEAT_FLUSH_BIT  = 5;
  localparam int FEAT_SID_MSB    = 2;
  localparam int ST_BSY          = 7;
  localparam int ST_RDY          = 6;
  localparam int ST_SE           = 5;
  localparam int ST_DWE          = 4;
  localparam int ST_DRQ          = 3;
  localparam int ST_ERR          = 0;
  localparam int ER_CRC          = 7;
  localparam int ER_IDN          = 4;
  localparam int ER_ABT          = 2;
  localparam int ER_TIME_LIMIT_EXPIRED         = 0;
  localparam int INT_DONE        = 0;
  localparam int INT_FAIL        = 1;
  localparam int INT_TIMEOUT     = 2;

  // ---------------------------------------------------------------
  // reset values, counts and timing
  // ---------------------------------------------------------------
  localparam logic [7:0]  STATUS_RESET       = 8'h40;
  localparam logic [16:0] ZERO_COUNT_SECTORS = 17'h1_0000;
  localparam int          WORDS_PER_SECTOR   = 256;
  localparam int          TIME_UNIT_US       = 1;
  localparam int          MIN_LIMIT          = 1;
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          US_NS              = 1000;
  localparam int          CYCLES_PER_US      = US_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_XFER  = 3'b010,
    ST_FLUSH = 3'b100
  } cmd_state_type;

endpackage

// >>> core/time_limit_timer.sv
// completion time limit timer counting whole microseconds
`timescale 1ns/10ps
`default_nettype none
module time_limit_timer
  import stream_dma_pkg::*;
#(
  parameter int CYC_PER_US = CYCLES_PER_US
) (
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        start,    // pulse: command accepted
  input  wire logic        run,      // level: command in progress
  input  wire logic        enable,   // limit in force for this command
  input  wire logic [23:0] limit_us, // limit in microseconds
  output logic             expired   // level until next start
);

  logic [15:0] cyc_r;
  logic [23:0] us_r;
  logic        armed_r;

  // ---------------------------------------------------------------
  // microsecond prescaler and elapsed counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r   <= 16'h0000;
      us_r    <= 24'h00_0000;
      armed_r <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cyc_r   <= 16'h0000;
      us_r    <= 24'h00_0000;
      armed_r <= enable;
      expired <= 1'b0;
    end else if (armed_r && run && !expired) begin
      if (cyc_r == 16'(CYC_PER_US - 1)) begin
        cyc_r <= 16'h0000;
        us_r  <= us_r + 24'h00_0001;
        // compare against the count about to be reached
        if (us_r + 24'h00_0001 >= limit_us) begin
          expired <= 1'b1;
        end
      end else begin
        cyc_r <= cyc_r + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/dma_host_model.sv
// host dma source model with random stalls and crc faults
`timescale 1ns/10ps
`default_nettype none
module dma_host_model (
  input  wire logic        pclk,       // clock
  input  wire logic        presetn,    // reset, active low
  input  wire logic        dma_req,    // device takes words
  input  wire logic        hold,       // offer no words
  input  wire logic        bad,        // flag crc on words
  output logic             dma_valid,  // word offered
  output logic      [15:0] dma_data,   // word
  output logic             dma_crc_err // crc flag of word
);
  // ----
  // word offer
  // ----
  // offers only while the device requests, so no stale flagged word outlives a command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_valid   <= 1'b0;
      dma_data    <= 16'h0000;
      dma_crc_err <= 1'b0;
    end else if (!dma_req) begin
      dma_valid   <= 1'b0;
      dma_crc_err <= 1'b0;
    end else begin
      dma_valid   <= !hold && ($urandom % 4 != 0);
      dma_data    <= hold ? ~dma_data : 16'($urandom);
      dma_crc_err <= bad;
    end
  end
endmodule
`default_nettype wire

// >>> verif/stream_write_dma_command_tb.sv
// self-checking bench for the streaming dma write command block
`timescale 1ns/10ps
`default_nettype none
module stream_write_dma_command_tb;
  import stream_dma_pkg::*;
  localparam int WPS_T = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ia;
  logic        dma_valid, dma_crc_err, dma_req, media_we, urgent_request;
  logic        flush_req, flush_done, hold, bad, se, idnf, mab;
  logic [11:0] paddr;
  logic [15:0] dma_data;
  logic [31:0] pwdata, prdata, q;
  int          n_errors, checks, nwe, cnt;

  stream_write_dma_command #(.WPS(WPS_T)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dma_valid, .dma_data,
    .dma_crc_err, .dma_req, .media_we, .media_data(), .media_lba(), .media_stream(),
    .urgent_request, .media_idnf(idnf), .media_abort(mab), .flush_req, .flush_done,
    .irq);
  dma_host_model host (.pclk, .presetn, .dma_req, .hold, .bad, .dma_valid, .dma_data,
    .dma_crc_err);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // words moved to media, counted per command
  always @(posedge pclk) if (media_we === 1'b1) nwe++;

  task automatic chk(input string s, input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // one apb transfer; watchdog bounds the wait for pready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic start(input logic [15:0] f, c, input logic [7:0] cmd);
    bus(1'b1, OFS_FEATURE, {16'h0000, f});
    bus(1'b1, OFS_COUNT, {16'h0000, c});
    bus(1'b1, OFS_LBA_LOW, $urandom);
    nwe = 0;
    bus(1'b1, OFS_COMMAND, {24'h00_0000, cmd});
  endtask
  task automatic idle();
    repeat (3000) begin
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      if (q[ST_BSY] === 1'b0) break;
    end
  endtask
  function automatic logic [31:0] st_exp(input logic s, e);
    return 32'h0000_0040 | {26'h000_0000, s, 4'h0, e};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #900_000;
    n_errors++;
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, flush_done, hold, bad, idnf, mab} = 9'h000;
    {paddr, pwdata} = 44'h000_0000_0000;
    void'($urandom(15877));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", q, st_exp(1'b0, 1'b0));
    bus(1'b0, 12'hFFC, 32'h0000_0000);
    chk("slverr", {q[30:0], se}, 32'h0000_0001);
    start(16'h0000, 16'h0001, 8'h35);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("bad code", q, st_exp(1'b0, 1'b1));
    $display("test reset and code done");
    for (int t = 0; t < 3; t++) begin
      cnt = $urandom_range(3, 1);
      start({8'h00, 8'($urandom) & 8'h87}, 16'(cnt), CMD_STREAM_WRITE);
      idle();
      chk("words", nwe, cnt * WPS_T);
      chk("status", q, st_exp(1'b0, 1'b0));
      bus(1'b1, OFS_INT_MASK, 32'h0000_0000);
      bus(1'b0, OFS_INT_STATUS, 32'h0000_0000);
      chk("done", q[INT_DONE], 1'b1);
      ia = irq;
      bus(1'b1, OFS_INT_MASK, 32'h0000_0007);
      bus(1'b0, OFS_INT_STATUS, 32'h0000_0000);
      chk("irq high", irq, 1'b1);
      bus(1'b1, OFS_INT_STATUS, 32'h0000_0007);
      bus(1'b0, OFS_INT_STATUS, 32'h0000_0000);
      chk("irq", {q[30:0], irq, ia}, 32'h0000_0000);
    end
    $display("test random writes done");
    for (int w = 0; w < 2; w++) begin
      bad <= 1'b1;
      start(w ? 16'h0040 : 16'h0000, 16'h0002, CMD_STREAM_WRITE);
      idle();
      bad <= 1'b0;
      chk("crc status", q, st_exp(w[0], !w[0]));
      bus(1'b0, w ? OFS_ERROR_LOG : OFS_ERROR, 32'h0000_0000);
      chk("crc kind", q[ER_CRC], 1'b1);
      if (w) chk("crc words", nwe, 2 * WPS_T);
    end
    $display("test crc done");
    start(16'h0020, 16'h0001, CMD_STREAM_WRITE);
    for (int k = 0; k < 3000 && flush_req !== 1'b1; k++) @(posedge pclk);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("flush busy", {q[ST_BSY], nwe[30:0]}, {1'b1, 31'(WPS_T)});
    flush_done <= 1'b1;
    @(posedge pclk);
    flush_done <= 1'b0;
    idle();
    chk("flush end", q, st_exp(1'b0, 1'b0));
    $display("test flush done");
    start(16'h0040, 16'h0001, CMD_STREAM_WRITE);
    idnf <= 1'b1;
    mab <= 1'b1;
    @(posedge pclk);
    idnf <= 1'b0;
    mab <= 1'b0;
    idle();
    chk("media err status", q, st_exp(1'b1, 1'b0));
    bus(1'b0, OFS_ERROR_LOG, 32'h0000_0000);
    chk("media err log", q, 32'h0000_0014);
    $display("test media errors done");
    hold <= 1'b1;
    start(16'h01C0, 16'h0000, CMD_STREAM_WRITE);
    bus(1'b0, OFS_SECTORS_LEFT, 32'h0000_0000);
    chk("count zero", q, {15'h0000, ZERO_COUNT_SECTORS});
    chk("urgent", urgent_request, 1'b1);
    idle();
    chk("limit status", q, st_exp(1'b1, 1'b0));
    bus(1'b0, OFS_ERROR_LOG, 32'h0000_0000);
    chk("limit log", q[ER_TIME_LIMIT_EXPIRED], 1'b1);
    hold <= 1'b0;
    $display("test time limit done");
    wrap_up();
  end
endmodule
`default_nettype wire
